// >>> hdl/mac_gap_station_regs.sv
// wishbone register slice: gap, reduced link support, station octets
`timescale 1ns/1ps
module mac_gap_station_regs
    import mac_cfg_pkg::*;
#(
    parameter logic [15:0] factory_station = 16'h0000, // value arbitrary
    parameter int tick_div = 1
)
(
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic cyc_in,
    input wire logic stb_in,
    input wire logic we_in,
    input wire logic [7:0] adr_in,
    input wire logic [3:0] sel_in,
    input wire logic [31:0] dat_in,
    input wire logic [15:0] factory_station_in,
    input wire logic rmii_mode_in,
    input wire logic tx_request_in,
    input wire logic carrier_in,
    output logic [31:0] dat_out,
    output logic ack_out,
    output logic tx_go_out,
    output logic deferring_out,
    output logic reduced_link_logic_reset_out,
    output logic reduced_link_speed_select_out,
    output logic [15:0] station_address_out
);
    logic [31:0] nonconsecutive_gap_config;
    logic [31:0] phy_support_control;
    logic [31:0] station_address_low_octets;
    logic [7:0] reg_base;
    logic [3:0] alias_bits;
    logic wide_ok;
    logic do_write;
    logic loaded;
    alias_op_t op;
    logic tick;
    logic [7:0] div_count;

    assign reg_base = {adr_in[7:4], 4'h0};
    assign alias_bits = adr_in[3:0];
    // byte lanes must form a halfword or a word for a write; a byte write is dropped
    assign wide_ok = (sel_in == 4'hf) || (sel_in == 4'h3)
        || (sel_in == 4'hc);
    assign do_write = cyc_in && stb_in && we_in && !ack_out && wide_ok;

    always_comb
    begin
        case (alias_bits)
            alias_clr: op = op_clr;
            alias_set: op = op_set;
            alias_inv: op = op_inv;
            default: op = op_write;
        endcase
    end

    function automatic logic [31:0] apply_op(input logic [31:0] cur,
        input logic [31:0] wdat, input logic [3:0] sel, input alias_op_t o,
        input logic [31:0] mask);
        logic [31:0] lane;
        logic [31:0] bits;
        logic [31:0] res;
        lane = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        bits = wdat & lane & mask;
        case (o)
            op_clr: res = cur & ~bits;
            op_set: res = cur | bits;
            op_inv: res = cur ^ bits;
            default: res = (cur & ~(lane & mask)) | bits;
        endcase
        return res & mask;
    endfunction

    // wishbone classic: one registered ack, one wait state, dropped the next cycle
    always_ff @(posedge clock_in)
    begin
        if (sys_rst_in)
            ack_out <= 1'b0;
        else
            ack_out <= cyc_in && stb_in && !ack_out;
    end

    always_ff @(posedge clock_in)
    begin
        if (sys_rst_in)
            nonconsecutive_gap_config <= gap_cfg_reset;
        else if (do_write && reg_base == gap_cfg_off)
            nonconsecutive_gap_config <= apply_op(nonconsecutive_gap_config,
                dat_in, sel_in, op, gap_cfg_mask);
    end

    always_ff @(posedge clock_in)
    begin
        if (sys_rst_in)
            phy_support_control <= phy_supp_reset;
        else if (do_write && reg_base == phy_supp_off)
            phy_support_control <= apply_op(phy_support_control, dat_in,
                sel_in, op, phy_supp_mask);
    end

    // factory value is a port, so it is caught after reset releases
    always_ff @(posedge clock_in)
    begin
        if (sys_rst_in)
        begin
            station_address_low_octets <= {16'h0000, factory_station};
            loaded <= 1'b0;
        end
        else if (!loaded)
        begin
            station_address_low_octets <= {16'h0000, factory_station_in};
            loaded <= 1'b1;
        end
        else if (do_write && reg_base == station_off)
            station_address_low_octets <= apply_op(
                station_address_low_octets, dat_in, sel_in, op,
                station_mask);
    end

    always_ff @(posedge clock_in)
    begin
        if (sys_rst_in)
            dat_out <= 32'h00000000;
        else if (cyc_in && stb_in && !we_in && !ack_out)
        begin
            case (reg_base)
                gap_cfg_off: dat_out <= nonconsecutive_gap_config;
                phy_supp_off: dat_out <= phy_support_control;
                station_off: dat_out <= station_address_low_octets;
                default: dat_out <= 32'h00000000;
            endcase
        end
    end

    // link outputs only act while the reduced link is the chosen phy mode
    always_ff @(posedge clock_in)
    begin
        if (sys_rst_in)
        begin
            reduced_link_logic_reset_out <= 1'b0;
            reduced_link_speed_select_out <= 1'b0;
            station_address_out <= 16'h0000;
        end
        else
        begin
            reduced_link_logic_reset_out <= rmii_mode_in
                && phy_support_control[link_reset_bit];
            reduced_link_speed_select_out <= rmii_mode_in
                && phy_support_control[link_speed_bit];
            station_address_out <= station_address_low_octets[15:0];
        end
    end

    // gap timebase: one enable per bit-time slot, slower at 10 Mbps
    always_ff @(posedge clock_in)
    begin
        if (sys_rst_in)
        begin
            div_count <= 8'h00;
            tick <= 1'b0;
        end
        else if (div_count == 8'h00)
        begin
            tick <= 1'b1;
            div_count <= phy_support_control[link_speed_bit]
                ? 8'(tick_div - 1) : 8'((tick_div * 10) - 1);
        end
        else
        begin
            tick <= 1'b0;
            div_count <= div_count - 8'h01;
        end
    end

    gap_timer #(
        .gap_w(gap_width)
    ) u_gap (
        .clock_in(clock_in),
        // gated copy: the reset bit must not act outside reduced link mode
        .sys_rst_in(sys_rst_in || reduced_link_logic_reset_out),
        .tick_in(tick),
        .start_in(tx_request_in),
        .carrier_in(carrier_in),
        .carrier_window_gap_in(
            nonconsecutive_gap_config[gap_one_lsb +: gap_width]),
        .nonconsecutive_frame_gap_in(
            nonconsecutive_gap_config[gap_two_lsb +: gap_width]),
        .tx_go_out(tx_go_out),
        .deferring_out(deferring_out)
    );

    byte_ignored_a: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        (cyc_in && stb_in && we_in && !ack_out && !wide_ok && loaded)
        |=> $stable(nonconsecutive_gap_config)
        && $stable(phy_support_control)
        && $stable(station_address_low_octets))
        else $error("byte write changed a register");
    supp_upper_zero_a: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        (phy_support_control & ~phy_supp_mask) == 32'h00000000)
        else $error("unimplemented support bit set");
    set_alias_a: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        (do_write && reg_base == phy_supp_off && op == op_set)
        |=> (phy_support_control & $past(phy_support_control))
        == $past(phy_support_control))
        else $error("set alias cleared a bit");
    speed_out_a: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        ##1 reduced_link_speed_select_out ==
        ($past(rmii_mode_in) && $past(phy_support_control[link_speed_bit])))
        else $error("speed output mismatch");
    link_reset_a: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        !rmii_mode_in |=> !reduced_link_logic_reset_out)
        else $error("link reset outside reduced mode");
    ack_once_a: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        ack_out |=> !ack_out)
        else $error("ack held two cycles");
endmodule

// >>> hdl/mac_cfg_pkg.sv
// constants for the mac gap, phy support and station address slice
// Summary of operation
// - carrier seen during first gap window makes the mac defer transmission.
// - carrier after first window: keep timing second gap, then transmit.
// - second gap field sets non-back-to-back gap; eighteen recommended.
// - reduced link reset bit one holds reduced link logic in reset.
// - reduced link speed bit one selects 100 Mbps, zero selects 10 Mbps.
// - reduced link bits affect only reduced link logic, not other phy modes; the speed bit also sets the gap tick rate in every mode.
// - station bits 15-8 are octet six, bits 7-0 octet five.
// - station address loads from factory value at reset; factory_station_in is loaded on the first clock after reset releases.
// - 16-bit and 32-bit accesses accepted, set, clear, invert aliases too.
// - byte-wide accesses are ignored with no state change; here only byte writes are dropped, a byte read still returns the register.
// - unimplemented support bits, 31-12 too, read zero and ignore writes.
package mac_cfg_pkg;
    localparam logic [7:0] gap_cfg_off = 8'h00;
    localparam logic [7:0] phy_supp_off = 8'h10;
    localparam logic [7:0] station_off = 8'h20;
    localparam logic [3:0] alias_clr = 4'h4;
    localparam logic [3:0] alias_set = 4'h8;
    localparam logic [3:0] alias_inv = 4'hc;
    localparam int gap_one_lsb = 8;
    localparam int gap_two_lsb = 0;
    localparam int gap_width = 7;
    localparam int link_reset_bit = 11;
    localparam int link_speed_bit = 8;
    localparam logic [31:0] gap_cfg_mask = 32'h00007f7f;
    localparam logic [31:0] phy_supp_mask = 32'h00000900;
    localparam logic [31:0] station_mask = 32'h0000ffff;
    localparam logic [31:0] gap_cfg_reset = 32'h00000c12;
    localparam logic [31:0] phy_supp_reset = 32'h00000000;
    localparam logic [6:0] gap_one_default = 7'h0c;
    localparam logic [6:0] gap_two_default = 7'h12;
    typedef enum logic [1:0] {op_write, op_clr, op_set, op_inv} alias_op_t;
    typedef enum logic [1:0] {gap_idle, gap_part_one, gap_part_two, gap_done}
        gap_state_t;
endpackage

// >>> hdl/gap_timer.sv
// non-back-to-back gap timer with carrier deference
`timescale 1ns/1ps
module gap_timer
    import mac_cfg_pkg::*;
#(
    parameter int gap_w = 7
)
(
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic tick_in,
    input wire logic start_in,
    input wire logic carrier_in,
    input wire logic [gap_w-1:0] carrier_window_gap_in,
    input wire logic [gap_w-1:0] nonconsecutive_frame_gap_in,
    output logic tx_go_out,
    output logic deferring_out
);
    gap_state_t state;
    logic [gap_w-1:0] count;

    always_ff @(posedge clock_in)
    begin
        if (sys_rst_in)
        begin
            state <= gap_idle;
            count <= '0;
            tx_go_out <= 1'b0;
            deferring_out <= 1'b0;
        end
        else
        begin
            tx_go_out <= 1'b0;
            case (state)
                gap_idle:
                begin
                    if (start_in)
                    begin
                        state <= gap_part_one;
                        count <= '0;
                        deferring_out <= 1'b0;
                    end
                end
                gap_part_one:
                begin
                    if (carrier_in)
                    begin
                        // carrier inside the window: back off and restart
                        deferring_out <= 1'b1;
                        count <= '0;
                    end
                    else if (tick_in)
                    begin
                        deferring_out <= 1'b0;
                        if (count >= carrier_window_gap_in)
                            state <= gap_part_two;
                        else
                            count <= count + 1'b1;
                    end
                end
                gap_part_two:
                begin
                    // carrier is ignored now, so a collision is accepted
                    if (tick_in)
                    begin
                        if (count >= nonconsecutive_frame_gap_in)
                        begin
                            state <= gap_done;
                            tx_go_out <= 1'b1;
                        end
                        else
                            count <= count + 1'b1;
                    end
                end
                gap_done:
                    state <= gap_idle;
                default:
                    state <= gap_idle;
            endcase
        end
    end

    carrier_defers_a: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        (state == gap_part_one && carrier_in) |=> deferring_out && !tx_go_out)
        else $error("carrier in first window did not defer");
    second_gap_go_a: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        tx_go_out |-> $past(state) == gap_part_two)
        else $error("transmit not from second gap");
    gap_count_a: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        tx_go_out |-> $past(count) >= $past(nonconsecutive_frame_gap_in))
        else $error("transmit before second gap elapsed");
endmodule

// >>> verification/phy_carrier_model.sv
// reduced link phy stand-in: raises carrier a set time after a trigger
`timescale 1ns/1ps
module phy_carrier_model
(
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic go_in,
    input wire logic [15:0] wait_in,
    input wire logic [15:0] len_in,
    output logic carrier_out
);
    logic [15:0] cnt;
    // counter saturates so a long idle never wraps into a false carrier
    always_ff @(posedge clock_in)
    begin
        if (sys_rst_in)
            cnt <= 16'h0000;
        else if (go_in)
            cnt <= 16'h0001;
        else if (cnt != 16'h0000 && cnt != 16'hffff)
            cnt <= cnt + 16'h0001;
    end
    always_ff @(posedge clock_in)
    begin
        carrier_out <= (cnt != 16'h0000) && (cnt >= wait_in) &&
            (cnt < wait_in + len_in);
    end
endmodule

// >>> verification/eth_mac_gap_phy_station_regs_tb_top.sv
// self-checking bench for the gap, phy support and station register slice
`timescale 1ns/1ps
module eth_mac_gap_phy_station_regs_tb_top;
    import mac_cfg_pkg::*;
    logic clock_in, sys_rst_in, cyc_in, stb_in, we_in, rmii, tx_req, phy_go;
    logic ack_out, tx_go_out, deferring_out, rl_rst, rl_spd, carrier, def;
    logic [7:0] adr_in;
    logic [3:0] sel_in;
    logic [31:0] dat_in, dat_out, lf, q, d;
    logic [15:0] fs, st_out, c_wait, c_len;
    logic [31:0] m [3];
    logic [31:0] msk [3];
    logic [3:0] sels [4];
    int err_count, total_checks, cycles, lat100, lat10, idx;
    mac_gap_station_regs #(.factory_station(16'h5a3c), .tick_div(1))
        mac_gap_station_regs_inst (.clock_in(clock_in),
        .sys_rst_in(sys_rst_in), .cyc_in(cyc_in), .stb_in(stb_in),
        .we_in(we_in), .adr_in(adr_in), .sel_in(sel_in), .dat_in(dat_in),
        .factory_station_in(fs), .rmii_mode_in(rmii),
        .tx_request_in(tx_req), .carrier_in(carrier), .dat_out(dat_out),
        .ack_out(ack_out), .tx_go_out(tx_go_out),
        .deferring_out(deferring_out),
        .reduced_link_logic_reset_out(rl_rst),
        .reduced_link_speed_select_out(rl_spd),
        .station_address_out(st_out));
    phy_carrier_model phy_carrier_model_inst (.clock_in(clock_in),
        .sys_rst_in(sys_rst_in), .go_in(phy_go), .wait_in(c_wait),
        .len_in(c_len), .carrier_out(carrier));
    function logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // expected register value after a write through one of the aliases
    function logic [31:0] nextv(input logic [31:0] o, input logic [31:0] w,
        input logic [3:0] s, input logic [3:0] a, input logic [31:0] k);
        logic [31:0] lm;
        lm = (s == 4'hf) ? 32'hffffffff : (s == 4'h3) ? 32'h0000ffff :
            (s == 4'hc) ? 32'hffff0000 : 32'h00000000;
        w = w & lm;
        case (a)
            4'h4: return o & ~(w & k);
            4'h8: return (o | w) & k;
            4'hc: return (o ^ w) & k;
            default: return ((o & ~lm) | w) & k;
        endcase
    endfunction
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, e);
        total_checks++;
        if (s !== e)
        begin
            $display("unexpected %s expected %h seen %h", nm, e, s);
            err_count++;
        end
    endtask
    // one classic cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
        input logic [31:0] v);
        int n;
        n = 0;
        @(posedge clock_in);
        {cyc_in, stb_in, we_in, adr_in, sel_in, dat_in} <= {2'b11, w, a, s, v};
        do
        begin
            @(posedge clock_in);
            n++;
        end
        while (ack_out !== 1'b1 && n < 50);
        q = dat_out;
        chk("ack", {31'b0, ack_out}, 32'h1);
        cyc_in <= 1'b0;
        stb_in <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] s,
        input logic [31:0] v);
        m[a[5:4]] = nextv(m[a[5:4]], v, s, a[3:0], msk[a[5:4]]);
        wb(1'b1, a, s, v);
    endtask
    task automatic rd(input logic [7:0] a);
        wb(1'b0, a, 4'hf, 32'h0);
        chk("read", q, m[a[5:4]]);
    endtask
    task automatic run_gap(input logic [6:0] g1, g2, input logic spd,
        input logic [15:0] w, l, output int lat);
        int n;
        rmii <= 1'b1;
        wr(8'h10, 4'hf, {23'b0, spd, 8'h00});
        wr(8'h00, 4'hf, {17'b0, g1, 1'b0, g2});
        c_wait <= w;
        c_len <= l;
        @(posedge clock_in);
        {tx_req, phy_go} <= 2'b11;
        @(posedge clock_in);
        {tx_req, phy_go} <= 2'b00;
        n = 0;
        def = 1'b0;
        while (tx_go_out !== 1'b1 && n < 3000)
        begin
            @(posedge clock_in);
            n++;
            if (deferring_out === 1'b1)
                def = 1'b1;
        end
        lat = n;
        chk("tx_go", {31'b0, tx_go_out}, 32'h1);
    endtask
    initial
    begin
        clock_in = 1'b0;
        forever #25 clock_in = ~clock_in;
    end
    always @(posedge clock_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            stop_test();
        end
    end
    initial
    begin
        {sys_rst_in, cyc_in, stb_in, we_in, rmii, tx_req, phy_go} = 7'b1000000;
        {adr_in, sel_in, dat_in, c_wait, c_len} = '0;
        lf = lfsr(32'h096e);
        fs = lf[15:0];
        sels = '{4'hf, 4'h3, 4'hc, 4'h1};
        msk = '{32'h00007f7f, 32'h00000900, 32'h0000ffff};
        m = '{32'h00000c12, 32'h0, {16'h0, lf[15:0]}};
        repeat (4) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        for (int i = 0; i < 3; i++)
            rd(8'(i * 16));
        // unmapped slot has no model entry, so drive the bus directly
        wb(1'b1, 8'h30, 4'hf, 32'hffffffff);
        wb(1'b0, 8'h30, 4'hf, 32'h0);
        chk("unmapped", q, 32'h0);
        // random traffic across registers, aliases, lane selects and phy mode
        for (int i = 0; i < 40; i++)
        begin
            lf = lfsr(lf);
            idx = (lf[1:0] == 2'b11) ? 1 : int'(lf[1:0]);
            rmii <= lf[8];
            d = lfsr(lf ^ 32'h5555aaaa);
            wr({2'b00, 2'(idx), lf[3:2], 2'b00}, sels[lf[7:6]], d);
            rd({2'b00, 2'(idx), 4'h0});
            chk("rl_rst", {31'b0, rl_rst}, {31'b0, m[1][11] & rmii});
            chk("rl_spd", {31'b0, rl_spd}, {31'b0, m[1][8] & rmii});
            chk("station", {16'b0, st_out}, m[2]);
        end
        run_gap(7'd2, 7'd6, 1'b1, 16'hffff, 16'h0, lat100);
        chk("defer", {31'b0, def}, 32'h0);
        run_gap(7'd10, 7'd12, 1'b1, 16'd3, 16'd3, lat10);
        chk("defer", {31'b0, def}, 32'h1);
        run_gap(7'd2, 7'd20, 1'b1, 16'd12, 16'd3, lat10);
        chk("defer", {31'b0, def}, 32'h0);
        run_gap(7'd0, 7'd6, 1'b1, 16'hffff, 16'h0, lat10);
        run_gap(7'd2, 7'd6, 1'b0, 16'hffff, 16'h0, lat10);
        chk("rate", {31'b0, lat10 > 5 * lat100}, 32'h1);
        stop_test();
    end
endmodule
